// *** verilog/gpwk_consts.svh ***
// register offsets, field positions and reset values for the gpio output and wake block
`ifndef GPWK_CONSTS_SVH
`define GPWK_CONSTS_SVH
`define GPWK_OFF_PA_OUT   32'h4000b00c
`define GPWK_OFF_PA_SET   32'h4000b010
`define GPWK_OFF_PA_CLR   32'h4000b014
`define GPWK_OFF_PB_OUT   32'h4000b40c
`define GPWK_OFF_PB_SET   32'h4000b410
`define GPWK_OFF_PB_CLR   32'h4000b414
`define GPWK_OFF_PC_OUT   32'h4000b80c
`define GPWK_OFF_PC_SET   32'h4000b810
`define GPWK_OFF_PC_CLR   32'h4000b814
`define GPWK_OFF_PA_WAKE  32'h4000bc08
`define GPWK_OFF_PB_WAKE  32'h4000bc0c
`define GPWK_OFF_PC_WAKE  32'h4000bc10
`define GPWK_OFF_FILT     32'h4000bc1c
`define GPWK_OFF_PA_CFG   32'h4000b000
`define GPWK_OFF_PB_CFG   32'h4000b400
`define GPWK_OFF_PC_CFG   32'h4000b800
`define GPWK_PORT_STRIDE  32'h00000400
`define GPWK_RST_OUT      8'h00
`define GPWK_RST_WAKE     8'h00
`define GPWK_RST_FILT     4'h0
`define GPWK_RST_CFG      32'h44444444
`define GPWK_FILT_IRQ4    3
`define GPWK_FILT_SER1    1
`define GPWK_FILT_PINS    0
`define GPWK_CFG_ANALOG   4'h0
`define GPWK_CFG_OUT_PP   4'h1
`define GPWK_CFG_IN_FLT   4'h4
`define GPWK_CFG_OUT_OD   4'h5
`define GPWK_CFG_IN_PULL  4'h8
`define GPWK_CFG_ALT_PP   4'h9
`define GPWK_CFG_ALT_OD   4'hd
`endif

// *** verilog/gpwk_pkg.sv ***
// types shared by the gpio output and wake block
package gpwk_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } gpwk_req_t;
  typedef struct packed {
    logic [23:0] out;
    logic [23:0] oe;
    logic [23:0] pull_en;
    logic [23:0] pull_up;
  } gpwk_pin_t;
endpackage

// *** verilog/gpwk_regs.sv ***
// three-port gpio output latch, set/clear strobes, wake enables and filter bits
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
`include "gpwk_consts.svh"
module gpwk_regs #(
  parameter int PORTS = 3
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire gpwk_pkg::gpwk_req_t bus_req,
  output logic [31:0]            bus_rdata,
  input  wire logic [23:0]       alt_out,
  output gpwk_pkg::gpwk_pin_t    pins,
  output logic [23:0]            wake_monitor_enable,
  output logic                   ext_irq4_wake_filter_en,
  output logic                   serial1_wake_filter_en,
  output logic                   pin_wake_filter_en
);
  logic [7:0]  out_q [PORTS];
  logic [7:0]  wake_q [PORTS];
  logic [31:0] cfg_q [PORTS];
  logic [3:0]  filt_q;
  logic [31:0] rdata_q;
  gpwk_pkg::gpwk_pin_t pins_q;
  logic [23:0] wake_o_q;
  logic [2:0]  filt_o_q;
  // per-pin next values, gathered so one process owns pins_q
  wire logic [23:0] pin_val;
  wire logic [23:0] pin_oe;
  wire logic [23:0] pin_pen;
  wire logic [23:0] pin_pup;

  wire logic        wr = bus_req.wr;
  wire logic        rd = bus_req.rd;
  wire logic [31:0] a  = bus_req.addr;
  wire logic [7:0]  wd = bus_req.wdata[7:0];
  wire logic        hit_filt = (a == `GPWK_OFF_FILT);

  logic [31:0] rd_mux [PORTS+1];
  assign rd_mux[0] = hit_filt ? {28'h0000000, filt_q} : 32'h00000000;

  genvar p;
  for (p = 0; p < PORTS; p++) begin : g_port
    wire logic [31:0] base = `GPWK_OFF_PA_OUT + 32'(p) * `GPWK_PORT_STRIDE;
    wire logic [31:0] cbas = `GPWK_OFF_PA_CFG + 32'(p) * `GPWK_PORT_STRIDE;
    wire logic [31:0] wadr = `GPWK_OFF_PA_WAKE + 32'(p) * 32'h00000004;
    wire logic hit_out  = (a == base);
    wire logic hit_set  = (a == base + 32'h00000004);
    wire logic hit_clr  = (a == base + 32'h00000008);
    wire logic hit_wake = (a == wadr);
    wire logic hit_cfgl = (a == cbas);
    wire logic hit_cfgh = (a == cbas + 32'h00000004);
    logic [7:0] out_d;
    always_comb begin
      out_d = out_q[p];
      if (wr && hit_out) out_d = wd;
      if (wr && hit_set) out_d = out_q[p] | wd;
      if (wr && hit_clr) out_d = out_q[p] & ~wd;
    end
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        out_q[p]  <= `GPWK_RST_OUT;
        wake_q[p] <= `GPWK_RST_WAKE;
        cfg_q[p]  <= `GPWK_RST_CFG;
      end else begin
        out_q[p] <= out_d;
        if (wr && hit_wake) wake_q[p] <= wd;
        if (wr && hit_cfgl) cfg_q[p][15:0] <= bus_req.wdata[15:0];
        if (wr && hit_cfgh) cfg_q[p][31:16] <= bus_req.wdata[15:0];
      end
    end
    assign rd_mux[p+1] = rd_mux[p]
      | (hit_out  ? {24'h000000, out_q[p]}  : 32'h00000000)
      | (hit_wake ? {24'h000000, wake_q[p]} : 32'h00000000)
      | (hit_cfgl ? {16'h0000, cfg_q[p][15:0]}  : 32'h00000000)
      | (hit_cfgh ? {16'h0000, cfg_q[p][31:16]} : 32'h00000000);
    genvar b;
    for (b = 0; b < 8; b++) begin : g_pin
      wire logic [3:0] mode = cfg_q[p][4*b+3:4*b];
      wire logic alt = (mode == `GPWK_CFG_ALT_PP) || (mode == `GPWK_CFG_ALT_OD);
      wire logic od  = (mode == `GPWK_CFG_OUT_OD) || (mode == `GPWK_CFG_ALT_OD);
      wire logic drv = (mode == `GPWK_CFG_OUT_PP) || (mode == `GPWK_CFG_OUT_OD) || alt;
      wire logic val = alt ? alt_out[8*p+b] : out_d[b];
      // open-drain only pulls low, released when high
      wire logic oe  = drv && !(od && val);
      assign pin_val[8*p+b] = val;
      assign pin_oe[8*p+b]  = oe;
      assign pin_pen[8*p+b] = (mode == `GPWK_CFG_IN_PULL);
      assign pin_pup[8*p+b] = out_d[b];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pins_q <= '0;
    end else begin
      pins_q.out     <= pin_val;
      pins_q.oe      <= pin_oe;
      pins_q.pull_en <= pin_pen;
      pins_q.pull_up <= pin_pup;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      filt_q   <= `GPWK_RST_FILT;
      rdata_q  <= 32'h00000000;
      wake_o_q <= 24'h000000;
      filt_o_q <= 3'h0;
    end else begin
      if (wr && hit_filt) begin
        filt_q <= bus_req.wdata[3:0] & 4'hb;
      end
      // unmapped reads answer zero
      rdata_q  <= rd ? rd_mux[PORTS] : 32'h00000000;
      wake_o_q <= {wake_q[2], wake_q[1], wake_q[0]};
      filt_o_q <= {filt_q[`GPWK_FILT_IRQ4], filt_q[`GPWK_FILT_SER1], filt_q[`GPWK_FILT_PINS]};
    end
  end

  assign bus_rdata               = rdata_q;
  assign pins                    = pins_q;
  assign wake_monitor_enable     = wake_o_q;
  assign ext_irq4_wake_filter_en = filt_o_q[2];
  assign serial1_wake_filter_en  = filt_o_q[1];
  assign pin_wake_filter_en      = filt_o_q[0];
endmodule

// *** sim/gpwk_sva.sv ***
// assertions on the gpio output and wake block ports
`timescale 1ns/1ns
module gpwk_sva (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire gpwk_pkg::gpwk_req_t bus_req,
  input wire logic [31:0]         bus_rdata,
  input wire gpwk_pkg::gpwk_pin_t pins,
  input wire logic [23:0]         wake_monitor_enable,
  input wire logic                pin_wake_filter_en
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // low address bits are unique across the mapped set
  wire logic [11:0] a = bus_req.addr[11:0];
  wire logic        w = bus_req.wr;
  wire logic        r = bus_req.rd;
  wire logic [7:0]  d = bus_req.wdata[7:0];
  wire logic [7:0]  o = pins.pull_up[7:0];
  sequence s_rd_out; r && a == 12'h00c; endsequence
  sequence s_wk; w && a == 12'hc08 ##1 1; endsequence
  property p_set; w && a == 12'h010 |=> o == ($past(o) | $past(d)); endproperty
  a_set: assert property (p_set) else $error("set wrong");
  property p_clr; w && a == 12'h014 |=> o == ($past(o) & ~$past(d)); endproperty
  a_clr: assert property (p_clr) else $error("clear wrong");
  property p_wr; w && a == 12'h00c |=> o == $past(d); endproperty
  a_wr: assert property (p_wr) else $error("latch write wrong");
  property p_hold; !w |=> $stable(o); endproperty
  a_hold: assert property (p_hold) else $error("latch moved");
  property p_rd; s_rd_out |=> bus_rdata == {24'h0, o}; endproperty
  a_rd: assert property (p_rd) else $error("latch read wrong");
  property p_rsc; r && a inside {12'h010, 12'h014} |=> bus_rdata == 0; endproperty
  a_rsc: assert property (p_rsc) else $error("strobe read nonzero");
  property p_wake; s_wk |=> wake_monitor_enable[7:0] == $past(d, 2); endproperty
  a_wake: assert property (p_wake) else $error("wake wrong");
  property p_filt; w && a == 12'hc1c ##1 1 |=> pin_wake_filter_en == $past(d[0], 2); endproperty
  a_filt: assert property (p_filt) else $error("filter wrong");
endmodule
bind gpwk_regs gpwk_sva u_sva (.*);

// *** sim/gpwk_pad.sv ***
// pad level model for the port pins
`timescale 1ns/1ns
module gpwk_pad (
  input wire logic                clk_sys,
  input wire gpwk_pkg::gpwk_pin_t pins,
  output logic [23:0]             pad
);
  logic t = 1'b0;
  // undriven unpulled pads wander, so stale values never pass
  always @(posedge clk_sys) t <= ~t;
  assign pad = (pins.oe & pins.out) | (~pins.oe & pins.pull_en & pins.pull_up)
             | (~pins.oe & ~pins.pull_en & {24{t}});
endmodule

// *** sim/tb.sv ***
// testbench for the gpio output and wake block
`timescale 1ns/1ns
`include "gpwk_consts.svh"
module tb;
  logic                clk_sys = 0;
  logic                rst_n = 0;
  gpwk_pkg::gpwk_req_t rq = '0;
  gpwk_pkg::gpwk_pin_t pins;
  logic [31:0]         rdat;
  logic [23:0]         wk, pad;
  logic                e4, s1, pf;
  logic [23:0]         alt = 24'h000004;
  int                  fails = 0, comparisons = 0, cyc = 0;
  gpwk_regs uut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(rq), .bus_rdata(rdat),
    .alt_out(alt), .pins(pins), .wake_monitor_enable(wk),
    .ext_irq4_wake_filter_en(e4), .serial1_wake_filter_en(s1), .pin_wake_filter_en(pf));
  gpwk_pad pm (.clk_sys(clk_sys), .pins(pins), .pad(pad));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc > 3000) begin
    fails++;
    wrap_up();
  end
  task chk(string n, logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, s);
    end
  endtask
  task wr(logic [31:0] a, d);
    @(posedge clk_sys);
    rq <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    rq.wr <= 0;
  endtask
  task rd(logic [31:0] a, e);
    @(posedge clk_sys);
    rq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_sys);
    rq.rd <= 0;
    #1 chk("rdata", rdat, e);
  endtask
  task t_ports();
    logic [31:0] b;
    for (int p = 0; p < 3; p++) begin
      b = `GPWK_OFF_PA_OUT + p * `GPWK_PORT_STRIDE;
      rd(b, 0);
      rd(`GPWK_OFF_PA_WAKE + 4 * p, 0);
      wr(b, 32'hffffff5a);
      rd(b, 32'h5a);
      wr(b + 4, 32'h81);
      rd(b, 32'hdb);
      wr(b + 8, 32'h4b);
      rd(b + 4, 0);
      rd(b + 8, 0);
      rd(b, 32'h90);
      wr(`GPWK_OFF_PA_WAKE + 4 * p, 32'hffffffa5);
      rd(`GPWK_OFF_PA_WAKE + 4 * p, 32'ha5);
      chk("wake", wk[8*p+:8], 8'ha5);
    end
  endtask
  task t_filt();
    wr(`GPWK_OFF_FILT, 32'hffffffff);
    rd(`GPWK_OFF_FILT, 32'hb);
    chk("filt", {e4, s1, pf}, 3'b111);
    rd(32'h4000bffc, 0);
  endtask
  task t_pins();
    wr(`GPWK_OFF_PA_CFG, 32'h5981);
    wr(`GPWK_OFF_PA_OUT, 32'h0a);
    #1 chk("oe", pins.oe[3:0], 4'b0101);
    chk("pad", pad[2:0], 3'b110);
    wr(`GPWK_OFF_PA_CLR, 32'h0a);
    #1 chk("oe", pins.oe[3:0], 4'b1101);
    chk("pad", pad[3:0], 4'b0100);
    @(posedge clk_sys);
    alt <= 24'h000000;
    @(posedge clk_sys);
    #1 chk("alt", pad[2], 1'b0);
  endtask
  task wrap_up();
    if (fails == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1;
    t_ports();
    t_filt();
    t_pins();
    wrap_up();
  end
endmodule
